// ===== rtl/evt_consts.svh
// Constants for the exception vector table block.
// Assumes inclusion by bare name from rtl/.
`ifndef EVT_CONSTS_SVH
`define EVT_CONSTS_SVH
`define EVT_NUM_POS      32
`define EVT_POS_W        5
`define EVT_ADDR_W       32
`define EVT_POS_SP       5'h00
`define EVT_POS_RESET    5'h01
`define EVT_POS_NMI      5'h02
`define EVT_POS_HARD     5'h03
`define EVT_POS_MEM      5'h04
`define EVT_POS_BUS      5'h05
`define EVT_POS_USAGE    5'h06
`define EVT_POS_SVC      5'h0b
`define EVT_POS_DBGMON   5'h0c
`define EVT_POS_PENDSVC  5'h0e
`define EVT_POS_TICK     5'h0f
`define EVT_POS_TMR1     5'h10
`define EVT_POS_TMR2     5'h11
`define EVT_POS_MGMT     5'h12
`define EVT_POS_BB       5'h13
`define EVT_POS_SLPTMR   5'h14
`define EVT_POS_SC1      5'h15
`define EVT_POS_SC2      5'h16
`define EVT_POS_SEC      5'h17
`define EVT_POS_MACTMR   5'h18
`define EVT_POS_MACTX    5'h19
`define EVT_POS_MACRX    5'h1a
`define EVT_POS_ADC      5'h1b
`define EVT_POS_EXTA     5'h1c
`define EVT_POS_EXTB     5'h1d
`define EVT_POS_NONE     5'h00
`define EVT_PEND_ZERO    32'h0000_0000
`define EVT_RSV_MASK     32'h0000_2780
`define EVT_ADDR_ZERO    32'h0000_0000
`define EVT_TABLE_BASE   32'h0000_0000
`define EVT_WORD_SHIFT   2
`endif

// ===== rtl/evt_pkg.sv
// Types for the exception vector table block.
// Assumes evt_consts.svh sits beside it.
`default_nettype none
`include "evt_consts.svh"
package evt_pkg;
  // Fetch sequencer states
  typedef enum logic [2:0] {
    EVT_ST_RESET = 3'b000,
    EVT_ST_SP    = 3'b001,
    EVT_ST_RV    = 3'b010,
    EVT_ST_RUN   = 3'b011,
    EVT_ST_VEC   = 3'b100
  } evt_state_t;

  // Request to the table memory
  typedef struct packed {
    logic                    valid;
    logic [`EVT_ADDR_W-1:0]  addr;
  } evt_fetch_t;

  // Result handed to the core
  typedef struct packed {
    logic                    valid;
    logic [`EVT_POS_W-1:0]   pos;
    logic [`EVT_ADDR_W-1:0]  handler;
  } evt_take_t;
endpackage : evt_pkg
`default_nettype wire

// ===== rtl/evt_vector_table.sv
// Exception vector table: pends exceptions and interrupts at fixed
// positions, picks the best by position, fetches the 32-bit word.
// Assumes one synchronous memory port answering with o_fetch.valid
// acknowledged by i_fetch_ack and data i_fetch_data.
// Operation
// - Reset first loads stack pointer from entry 0
// - Reset vector 1 taken, then thread level
// - NMI preempted only by reset
// - Each position but 0 (stack word) holds 32-bit handler address
// - Hard fault when fault handler cannot activate
// - Memory protection mismatch raises position 4
// - Bus fault precise or imprecise, position 5
// - Usage fault raises position 6
// - Service call instruction raises position 11
// - Debug monitor only enabled, not halting, priority
// - Pendable service pended by software only
// - System tick fire raises position 15
// - Timers 1 and 2 to 16, 17
// - Management interrupt to position 18
// - Baseband interrupt to position 19
// - Sleep timer interrupt to position 20
// - Serial controllers to 21 and 22
// - Security interrupt to position 23
// - MAC timer interrupt to position 24
// - MAC transmit, receive to 25, 26
// - ADC interrupt to position 27
// - External lines A, B to 28, 29
`timescale 1ns/100ps
`default_nettype none
`include "evt_consts.svh"

module evt_vector_table
  import evt_pkg::*;
(
  input  wire logic                    i_mclk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_warm_reset,
  input  wire logic                    i_nmi,
  input  wire logic                    i_mem_mismatch,
  input  wire logic                    i_bus_fault_precise,
  input  wire logic                    i_bus_fault_imprecise,
  input  wire logic                    i_usage_fault,
  input  wire logic                    i_cfg_fault_en,
  input  wire logic                    i_service_call,
  input  wire logic                    i_debug_mon_req,
  input  wire logic                    i_debug_mon_en,
  input  wire logic                    i_halting,
  input  wire logic                    i_sw_pend_service,
  input  wire logic                    i_system_tick_fire,
  input  wire logic                    i_timer1_irq,
  input  wire logic                    i_timer2_irq,
  input  wire logic                    i_mgmt_irq,
  input  wire logic                    i_baseband_irq,
  input  wire logic                    i_sleep_timer_irq,
  input  wire logic                    i_serial1_irq,
  input  wire logic                    i_serial2_irq,
  input  wire logic                    i_security_irq,
  input  wire logic                    i_mac_timer_irq,
  input  wire logic                    i_mac_tx_irq,
  input  wire logic                    i_mac_rx_irq,
  input  wire logic                    i_adc_irq,
  input  wire logic                    i_external_line_a_interrupt,
  input  wire logic                    i_external_line_b_interrupt,
  input  wire logic                    i_fetch_ack,
  input  wire logic [`EVT_ADDR_W-1:0]  i_fetch_data,
  input  wire logic                    i_return,
  output var  evt_fetch_t              o_fetch,
  output var  logic [`EVT_ADDR_W-1:0]  o_sp,
  output var  logic                    o_sp_valid,
  output var  evt_take_t               o_take,
  output var  logic [`EVT_POS_W-1:0]   o_active_pos,
  output var  logic                    o_thread
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte address of a table position
  function automatic logic [`EVT_ADDR_W-1:0] pos_addr(
    input logic [`EVT_POS_W-1:0] pos
  );
    pos_addr = `EVT_TABLE_BASE +
      ({{(`EVT_ADDR_W-`EVT_POS_W){1'b0}}, pos} << `EVT_WORD_SHIFT);
  endfunction : pos_addr

  // One-hot bit for a position
  function automatic logic [`EVT_NUM_POS-1:0] pos_bit(
    input logic [`EVT_POS_W-1:0] pos
  );
    pos_bit = {{(`EVT_NUM_POS-1){1'b0}}, 1'b1} << pos;
  endfunction : pos_bit

  ////////////////////////////////////////////////////////////////////
  // State

  evt_state_t               state_reg;      // Fetch sequencer
  evt_state_t               state_next;     // Its next value
  logic [`EVT_NUM_POS-1:0]  pend_reg;       // Pending positions
  logic [`EVT_NUM_POS-1:0]  raise_vec;      // New events this cycle
  logic [`EVT_POS_W-1:0]    active_reg;     // Active position, 0=thread
  logic [`EVT_POS_W-1:0]    sel_pos_reg;    // Position being fetched
  logic [`EVT_POS_W-1:0]    best_pos;       // Best pending candidate
  logic                     best_ok;        // Candidate may preempt
  logic                     fault_blocked;  // Fault handler unusable
  logic                     take_fault_hard;

  ////////////////////////////////////////////////////////////////////
  // Event gathering

  // Faults divert to hard fault when their own handler cannot run
  always_comb begin
    // Disabled handler, or current activation at position 6 or better (fault class included)
    fault_blocked = !i_cfg_fault_en ||
      ((active_reg != `EVT_POS_NONE) &&
       (active_reg <= `EVT_POS_USAGE));
    take_fault_hard = fault_blocked &&
      (i_mem_mismatch || i_bus_fault_precise ||
       i_bus_fault_imprecise || i_usage_fault);
  end

  // Map every source to its fixed position
  always_comb begin
    raise_vec = `EVT_PEND_ZERO;
    if (i_nmi) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_NMI);
    end
    if (take_fault_hard) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_HARD);
    end else begin
      // Own fault handlers
      if (i_mem_mismatch) begin
        raise_vec = raise_vec | pos_bit(`EVT_POS_MEM);
      end
      if (i_bus_fault_precise || i_bus_fault_imprecise) begin
        raise_vec = raise_vec | pos_bit(`EVT_POS_BUS);
      end
      if (i_usage_fault) begin
        raise_vec = raise_vec | pos_bit(`EVT_POS_USAGE);
      end
    end
    if (i_service_call) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_SVC);
    end
    // Debug monitor only while enabled and not halting
    if (i_debug_mon_req && i_debug_mon_en && !i_halting) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_DBGMON);
    end
    // Software request is the only source
    if (i_sw_pend_service) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_PENDSVC);
    end
    if (i_system_tick_fire) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_TICK);
    end
    // Peripheral lines
    if (i_timer1_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_TMR1);
    end
    if (i_timer2_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_TMR2);
    end
    if (i_mgmt_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_MGMT);
    end
    if (i_baseband_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_BB);
    end
    if (i_sleep_timer_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_SLPTMR);
    end
    if (i_serial1_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_SC1);
    end
    if (i_serial2_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_SC2);
    end
    if (i_security_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_SEC);
    end
    if (i_mac_timer_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_MACTMR);
    end
    if (i_mac_tx_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_MACTX);
    end
    if (i_mac_rx_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_MACRX);
    end
    if (i_adc_irq) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_ADC);
    end
    if (i_external_line_a_interrupt) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_EXTA);
    end
    if (i_external_line_b_interrupt) begin
      raise_vec = raise_vec | pos_bit(`EVT_POS_EXTB);
    end
    // Reserved positions can never pend
    raise_vec = raise_vec & ~`EVT_RSV_MASK;
  end

  ////////////////////////////////////////////////////////////////////
  // Selection: lowest position wins

  always_comb begin
    best_pos = `EVT_POS_NONE;
    for (int i = `EVT_NUM_POS - 1; i > 0; i--) begin
      if (pend_reg[i]) begin
        best_pos = i[`EVT_POS_W-1:0];
      end
    end
    // Preempt only a lower-priority activation (higher number);
    // nothing but reset outranks NMI since reset has position 1
    best_ok = (best_pos != `EVT_POS_NONE) &&
      ((active_reg == `EVT_POS_NONE) ||
       (best_pos < active_reg));
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      EVT_ST_RESET: begin
        state_next = EVT_ST_SP;
      end
      EVT_ST_SP: begin
        if (i_fetch_ack) begin
          state_next = EVT_ST_RV;
        end
      end
      EVT_ST_RV: begin
        if (i_fetch_ack) begin
          state_next = EVT_ST_RUN;
        end
      end
      EVT_ST_RUN: begin
        if (best_ok) begin
          state_next = EVT_ST_VEC;
        end
      end
      EVT_ST_VEC: begin
        if (i_fetch_ack) begin
          state_next = EVT_ST_RUN;
        end
      end
      default: begin
        state_next = EVT_ST_RESET;
      end
    endcase
    // Warm reset restarts the whole sequence
    if (i_warm_reset) begin
      state_next = EVT_ST_RESET;
    end
  end

  // Sequencer register
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= EVT_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pending bits: a new event wins over the clear on take
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_reg <= `EVT_PEND_ZERO;
    end else if (i_warm_reset) begin
      pend_reg <= `EVT_PEND_ZERO;
    end else if (state_reg == EVT_ST_VEC && i_fetch_ack) begin
      pend_reg <= (pend_reg & ~pos_bit(sel_pos_reg)) | raise_vec;
    end else begin
      pend_reg <= pend_reg | raise_vec;
    end
  end

  // Selected position latched when a fetch starts
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_pos_reg <= `EVT_POS_NONE;
    end else if (state_reg == EVT_ST_RUN && best_ok) begin
      sel_pos_reg <= best_pos;
    end
  end

  // Active position; reset drops to thread level after its vector
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      active_reg <= `EVT_POS_NONE;
    end else if (i_warm_reset || state_reg == EVT_ST_RV) begin
      active_reg <= `EVT_POS_NONE;
    end else if (state_reg == EVT_ST_VEC && i_fetch_ack) begin
      active_reg <= sel_pos_reg;
    end else if (state_reg == EVT_ST_RUN && i_return) begin
      active_reg <= `EVT_POS_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Table fetch request

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fetch <= '0;
    end else begin
      unique case (state_next)
        EVT_ST_SP: begin
          o_fetch.valid <= 1'b1;
          o_fetch.addr  <= pos_addr(`EVT_POS_SP);
        end
        EVT_ST_RV: begin
          o_fetch.valid <= 1'b1;
          o_fetch.addr  <= pos_addr(`EVT_POS_RESET);
        end
        EVT_ST_VEC: begin
          o_fetch.valid <= 1'b1;
          o_fetch.addr  <= (state_reg == EVT_ST_RUN) ?
            pos_addr(best_pos) : o_fetch.addr;
        end
        default: begin
          o_fetch.valid <= 1'b0;
          o_fetch.addr  <= `EVT_ADDR_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Results to the core

  // Stack pointer word from position 0
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sp       <= `EVT_ADDR_ZERO;
      o_sp_valid <= 1'b0;
    end else if (i_warm_reset) begin
      o_sp_valid <= 1'b0;
    end else if (state_reg == EVT_ST_SP && i_fetch_ack) begin
      o_sp       <= i_fetch_data;
      o_sp_valid <= 1'b1;
    end
  end

  // Handler address pulse, one cycle
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_take <= '0;
    end else begin
      o_take.valid <= 1'b0;
      if (!i_warm_reset && i_fetch_ack &&
          (state_reg == EVT_ST_RV || state_reg == EVT_ST_VEC)) begin
        o_take.valid   <= 1'b1;
        o_take.pos     <= (state_reg == EVT_ST_RV) ?
          `EVT_POS_RESET : sel_pos_reg;
        o_take.handler <= i_fetch_data;
      end
    end
  end

  // Status
  always_comb begin
    o_active_pos = active_reg;
    o_thread     = (state_reg == EVT_ST_RUN || state_reg == EVT_ST_VEC)
                   && (active_reg == `EVT_POS_NONE);
  end

endmodule : evt_vector_table
`default_nettype wire

// ===== tb/evt_vector_table_sva.sv
// Concurrent checks on the vector table ports.
// Assumes a bind onto evt_vector_table and one clock domain.
`timescale 1ns/100ps
`default_nettype none
module evt_vector_table_sva
  import evt_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rstn,
  input wire logic        i_warm_reset,
  input wire logic        i_fetch_ack,
  input wire logic [31:0] i_fetch_data,
  input wire evt_fetch_t  o_fetch,
  input wire logic [31:0] o_sp,
  input wire logic        o_sp_valid,
  input wire evt_take_t   o_take,
  input wire logic [4:0]  o_active_pos,
  input wire logic        o_thread
);
  // Reserved positions 7 to 10 and 13
  localparam logic [31:0] RSV = 32'h0000_2780;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////
  // Accepted fetches, split by stack word or vector
  sequence s_ack; o_fetch.valid && i_fetch_ack && !i_warm_reset; endsequence
  sequence s_sp_ack; s_ack ##0 o_fetch.addr == 32'h0000_0000; endsequence
  sequence s_vec_ack; s_ack ##0 o_fetch.addr != 32'h0000_0000; endsequence
  property p_sp_load;
    s_sp_ack ##1 !i_warm_reset |-> o_sp_valid && o_sp == $past(i_fetch_data);
  endproperty
  a_sp_load: assert property (p_sp_load)
    else $error("stack word not loaded from entry 0");
  property p_sp_stable;
    o_sp_valid && !i_warm_reset |=> o_sp_valid && $stable(o_sp);
  endproperty
  a_sp_stable: assert property (p_sp_stable)
    else $error("stack word changed");
  property p_take_ans;
    s_vec_ack ##1 !i_warm_reset |-> o_take.valid &&
      o_take.handler == $past(i_fetch_data) &&
      {25'h0, o_take.pos, 2'h0} == $past(o_fetch.addr);
  endproperty
  a_take_ans: assert property (p_take_ans)
    else $error("handler word or position wrong");
  property p_take_pulse; o_take.valid |=> !o_take.valid; endproperty
  a_take_pulse: assert property (p_take_pulse)
    else $error("take pulse longer than one cycle");
  property p_fetch_hold;
    o_fetch.valid && !i_fetch_ack && !i_warm_reset
      |=> o_fetch.valid && $stable(o_fetch.addr);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold)
    else $error("fetch dropped before answer");
  property p_fetch_addr;
    o_fetch.valid |-> o_fetch.addr[1:0] == 2'h0 &&
      o_fetch.addr[31:7] == 25'h0 && !RSV[o_fetch.addr[6:2]];
  endproperty
  a_fetch_addr: assert property (p_fetch_addr)
    else $error("fetch address outside table");
  property p_take_rsv; o_take.valid |-> !RSV[o_take.pos]; endproperty
  a_take_rsv: assert property (p_take_rsv)
    else $error("reserved position taken");
  property p_reset_thread;
    o_take.valid && o_take.pos == 5'h01 |-> o_thread && o_active_pos == 5'h00;
  endproperty
  a_reset_thread: assert property (p_reset_thread)
    else $error("no thread level after reset vector");
  property p_preempt;
    o_take.valid && o_take.pos != 5'h01 && $past(o_active_pos) != 5'h00
      |-> o_take.pos < $past(o_active_pos);
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("preempted by equal or lower priority");
  property p_warm;
    i_warm_reset |=> !o_sp_valid && !o_take.valid && !o_fetch.valid;
  endproperty
  a_warm: assert property (p_warm)
    else $error("warm reset did not restart");
endmodule : evt_vector_table_sva
bind evt_vector_table evt_vector_table_sva evt_vector_table_sva_inst (
  .i_mclk, .i_rstn, .i_warm_reset, .i_fetch_ack, .i_fetch_data, .o_fetch,
  .o_sp, .o_sp_valid, .o_take, .o_active_pos, .o_thread);
`default_nettype wire

// ===== tb/evt_table_mem.sv
// Table memory model answering vector fetches after i_wait cycles.
// Assumes requests held until acknowledged; bus inverts when idle.
`timescale 1ns/100ps
`default_nettype none
module evt_table_mem
  import evt_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire evt_fetch_t  i_fetch,
  input  wire logic [3:0]  i_wait,
  output var  logic        o_ack,
  output var  logic [31:0] o_data
);
  logic [3:0] wait_reg; // Cycles spent on current request
  ////////////////////////////////////////////////////////////////////////
  // Answer after i_wait cycles, one-cycle ack, with the word of the addressed entry
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ack    <= 1'b0;
      wait_reg <= 4'h0;
      o_data   <= 32'h0000_0000;
    end else if (o_ack) begin
      o_ack    <= 1'b0;
      wait_reg <= 4'h0;
      o_data   <= ~o_data;
    end else if (i_fetch.valid && wait_reg >= i_wait) begin
      o_ack    <= 1'b1;
      o_data   <= 32'h5A00_0000 | i_fetch.addr;
    end else begin
      wait_reg <= i_fetch.valid ? wait_reg + 4'h1 : 4'h0;
      o_data   <= ~o_data; // Idle bus carries no stale word
    end
  end
endmodule : evt_table_mem
`default_nettype wire

// ===== tb/evt_vector_table_tb.sv
// Testbench for the vector table: boot, every source, priority.
// Assumes the table memory model on the fetch port.
`timescale 1ns/100ps
`default_nettype none
`define EVT_CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  mismatches++; $display("ERROR %0t: got %h exp %h", $time, got, exp); end end
module evt_vector_table_tb;
  import evt_pkg::*;
  logic        mclk, rstn, warm, cfg_en, dbg_en, halting, ret;
  logic [22:0] ev;       // Event sources, one bit each
  logic [3:0]  mem_wait; // Memory answer delay
  logic        ack, sp_valid, thread;
  logic [31:0] data, sp;
  evt_fetch_t  fetch;
  evt_take_t   take;
  logic [4:0]  active_pos;
  int          mismatches, tests_run, cycles;
  // Expected position of each event source bit
  localparam logic [4:0] POS [23] = '{5'h02, 5'h04, 5'h05, 5'h05, 5'h06,
    5'h0b, 5'h0c, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15,
    5'h16, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  evt_vector_table evt_vector_table_inst (.i_mclk(mclk), .i_rstn(rstn),
    .i_warm_reset(warm), .i_nmi(ev[0]), .i_mem_mismatch(ev[1]),
    .i_bus_fault_precise(ev[2]), .i_bus_fault_imprecise(ev[3]),
    .i_usage_fault(ev[4]), .i_cfg_fault_en(cfg_en), .i_service_call(ev[5]),
    .i_debug_mon_req(ev[6]), .i_debug_mon_en(dbg_en), .i_halting(halting),
    .i_sw_pend_service(ev[7]), .i_system_tick_fire(ev[8]),
    .i_timer1_irq(ev[9]), .i_timer2_irq(ev[10]), .i_mgmt_irq(ev[11]),
    .i_baseband_irq(ev[12]), .i_sleep_timer_irq(ev[13]),
    .i_serial1_irq(ev[14]), .i_serial2_irq(ev[15]), .i_security_irq(ev[16]),
    .i_mac_timer_irq(ev[17]), .i_mac_tx_irq(ev[18]), .i_mac_rx_irq(ev[19]),
    .i_adc_irq(ev[20]), .i_external_line_a_interrupt(ev[21]),
    .i_external_line_b_interrupt(ev[22]), .i_fetch_ack(ack),
    .i_fetch_data(data), .i_return(ret), .o_fetch(fetch), .o_sp(sp),
    .o_sp_valid(sp_valid), .o_take(take), .o_active_pos(active_pos),
    .o_thread(thread));
  evt_table_mem evt_table_mem_inst (.i_mclk(mclk), .i_rstn(rstn),
    .i_fetch(fetch), .i_wait(mem_wait), .o_ack(ack), .o_data(data));
  ////////////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // Word the memory model holds at a position
  function automatic logic [31:0] word_of(input logic [4:0] p);
    return 32'h5A00_0000 | {25'h0, p, 2'h0};
  endfunction : word_of
  // Drive just after the rising edge
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick
  // One source high for exactly one sampling edge
  task automatic pulse(input int i);
    tick();
    ev[i] = 1'b1;
    tick();
    ev = '0;
  endtask : pulse
  // Handler exit strobe, one cycle
  task automatic do_ret();
    tick();
    ret = 1'b1;
    tick();
    ret = 1'b0;
  endtask : do_ret
  // Wait a bounded time for one take pulse
  task automatic wait_take(input int n, output logic got, output evt_take_t t);
    got = 1'b0;
    t = '0;
    for (int k = 0; k < n && !got; k++) begin
      tick();
      if (take.valid === 1'b1) begin
        got = 1'b1;
        t = take;
      end
    end
  endtask : wait_take
  task automatic expect_take(input logic [4:0] p);
    logic got;
    evt_take_t t;
    wait_take(40, got, t);
    `EVT_CHECK(got, 1'b1)
    `EVT_CHECK(t.pos, p)
    `EVT_CHECK(t.handler, word_of(p))
  endtask : expect_take
  task automatic expect_none(input int n);
    logic got;
    evt_take_t t;
    wait_take(n, got, t);
    `EVT_CHECK(got, 1'b0)
  endtask : expect_none
  // Stack word, then reset vector, then thread level
  task automatic boot();
    for (int k = 0; k < 30 && sp_valid !== 1'b1; k++) tick();
    `EVT_CHECK(sp_valid, 1'b1)
    `EVT_CHECK(sp, word_of(5'h00))
    expect_take(5'h01);
    `EVT_CHECK(thread, 1'b1)
  endtask : boot
  task automatic sweep(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      mem_wait = 4'(i % 4);
      pulse(i);
      expect_take(POS[i]);
      do_ret();
    end
    mem_wait = 4'h0;
    $display("test sweep %0d to %0d done", lo, hi);
  endtask : sweep
  task automatic t_hard();
    cfg_en = 1'b0;
    pulse(1);
    expect_take(5'h03);
    do_ret();
    pulse(4);
    expect_take(5'h03);
    do_ret();
    cfg_en = 1'b1;
    // Fault while a fault-class handler runs: priority diverts it
    pulse(4);
    expect_take(5'h06);
    pulse(1);
    expect_take(5'h03);
    do_ret();
    $display("test hard fault done");
  endtask : t_hard
  task automatic t_dbg();
    dbg_en = 1'b0;
    pulse(6);
    expect_none(20);
    dbg_en = 1'b1;
    halting = 1'b1;
    pulse(6);
    expect_none(20);
    halting = 1'b0;
    // Monitor request below the active priority waits for return
    pulse(4);
    expect_take(5'h06);
    pulse(6);
    expect_none(20);
    do_ret();
    expect_take(5'h0c);
    do_ret();
    $display("test debug refusal done");
  endtask : t_dbg
  // Same-cycle requests, preemption and blocking
  task automatic t_prio();
    tick();
    ev[10:9] = 2'h3;
    tick();
    ev = '0;
    expect_take(5'h10);
    do_ret();
    expect_take(5'h11);
    pulse(0);
    expect_take(5'h02);
    `EVT_CHECK(active_pos, 5'h02)
    pulse(20);
    expect_none(20);
    do_ret();
    expect_take(5'h1b);
    do_ret();
    $display("test priority done");
  endtask : t_prio
  task automatic t_warm();
    mem_wait = 4'h3;
    warm = 1'b1;
    tick();
    tick();
    `EVT_CHECK(sp_valid, 1'b0)
    warm = 1'b0;
    boot();
    mem_wait = 4'h0;
    $display("test warm reset done");
  endtask : t_warm
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {mclk, rstn, warm, halting, ret} = '0;
    {cfg_en, dbg_en} = 2'h3;
    ev = '0;
    mem_wait = 4'h0;
    repeat (3) tick();
    rstn = 1'b1;
    boot();
    $display("test boot done");
    sweep(0, 4);
    sweep(5, 8);
    sweep(9, 15);
    sweep(16, 22);
    t_hard();
    t_dbg();
    t_prio();
    t_warm();
    conclude();
  end
endmodule : evt_vector_table_tb
`default_nettype wire
